// [design/cwgcs_params.svh]
// Constants of the CRTC write guard and video clock select block.
// Assumes host I/O addresses are 16-bit port numbers, indexes are 8 bits.
`ifndef CWGCS_PARAMS_SVH
`define CWGCS_PARAMS_SVH

`define CWGCS_PORT_MISC_WR       16'h03C2
`define CWGCS_PORT_MISC_RD       16'h03CC
`define CWGCS_PORT_GFX_INDEX     16'h03CE
`define CWGCS_PORT_GFX_DATA      16'h03CF
`define CWGCS_PORT_CRTC_IDX_MONO 16'h03B4
`define CWGCS_PORT_CRTC_DAT_MONO 16'h03B5
`define CWGCS_PORT_CRTC_IDX_CLR  16'h03D4
`define CWGCS_PORT_CRTC_DAT_CLR  16'h03D5

`define CWGCS_IDX_WRITE_GUARD    8'h83
`define CWGCS_IDX_CLOCK_SELECT   8'h84

`define CWGCS_CRTC_COUNT         8'h19
`define CWGCS_PAL_COUNT          5'h10

`define CWGCS_GUARD_PAL          6
`define CWGCS_GUARD_TOTAL        4
`define CWGCS_GUARD_BLANK        3
`define CWGCS_GUARD_VDE          2
`define CWGCS_GUARD_TIMING       1
`define CWGCS_GUARD_VERT         0
`define CWGCS_GUARD_MASK         8'h5F
`define CWGCS_GUARD_RESET        8'h00

`define CWGCS_CLK_SRC            7
`define CWGCS_CLK_CODE_HI        5
`define CWGCS_CLK_CODE_MID       4
`define CWGCS_CLK_CODE_LO        2
`define CWGCS_CLK_HALVE          1
`define CWGCS_CLK_MASK           8'hBE
`define CWGCS_CLK_RESET          8'h20

`define CWGCS_MISC_CLK_HI        3
`define CWGCS_MISC_CLK_LO        2
`define CWGCS_MISC_RESET         2'h0

`endif

// [design/cwgcs_pkg.sv]
// Types shared by the CRTC write guard and clock select block.
// Assumes nothing beyond the constants header.
`default_nettype none

package cwgcs_pkg;

  typedef logic [24:0][7:0] cwgcs_crtc_file_t;
  typedef logic [15:0][5:0] cwgcs_pal_file_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wrData;
    logic        wr;
    logic        rd;
  } cwgcs_host_req_s;

  typedef struct packed {
    logic [4:0] index;
    logic [5:0] data;
    logic       wr;
  } cwgcs_attr_req_s;

  typedef struct packed {
    logic [3:0] code;
    logic       halve;
  } cwgcs_clk_sel_s;

endpackage : cwgcs_pkg
`default_nettype wire

// [design/cwgcs_core.sv]
// Write guard over CRTC timing and attribute palette, plus video clock select.
// Assumes host I/O cycles arrive as one-cycle strobes on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "cwgcs_params.svh"

module cwgcs_core (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire cwgcs_pkg::cwgcs_host_req_s hostReq,
  input  wire cwgcs_pkg::cwgcs_attr_req_s attrReq,
  output logic [7:0]                      hostRdData,
  output logic                            hostRdValid,
  output cwgcs_pkg::cwgcs_crtc_file_t     crtcTiming,
  output cwgcs_pkg::cwgcs_pal_file_t      paletteEntries,
  output cwgcs_pkg::cwgcs_clk_sel_s       videoClockSel
);

  logic [7:0]                  timingWriteGuard;
  logic [7:0]                  videoClockSelect;
  logic [1:0]                  miscClk;
  logic [7:0]                  gfxIndex;
  logic [7:0]                  crtcIndex;
  cwgcs_pkg::cwgcs_crtc_file_t crtcStd;
  cwgcs_pkg::cwgcs_crtc_file_t crtcWork;
  logic                        crtcDataHit;
  logic                        crtcWrite;
  logic [7:0]                  wrMask;
  logic [7:0]                  next_rdData;
  logic [3:0]                  next_code;

  // Union of every guard that covers a bit; a set bit in the result is protected
  function automatic logic [7:0] prot_mask(input logic [7:0] idx, input logic [7:0] g);
    logic t;
    logic b;
    logic d;
    logic m;
    logic v;
    logic [7:0] r;
    t = g[`CWGCS_GUARD_TOTAL];
    b = g[`CWGCS_GUARD_BLANK];
    d = g[`CWGCS_GUARD_VDE];
    m = g[`CWGCS_GUARD_TIMING];
    v = g[`CWGCS_GUARD_VERT];
    case (idx)
      8'h00: r = {8{t}};
      8'h02: r = {8{b}};
      8'h03: r = {8{b}} & 8'h1F;
      8'h04: r = {8{t}};
      8'h05: r = ({8{t}} & 8'h1F) | ({8{b}} & 8'h80);
      8'h06: r = {8{t | v}};
      8'h07: r = ({8{t}} & 8'hA5) | ({8{b}} & 8'h08) | ({8{d | m}} & 8'h42)
               | ({8{v}} & 8'hAD);
      8'h09: r = {8{m}} | ({8{b | v}} & 8'h20);
      8'h0A: r = {8{m}};
      8'h0B: r = {8{m}};
      8'h10: r = {8{t | v}};
      8'h11: r = {8{t}} | ({8{v}} & 8'h0F);
      8'h12: r = {8{d | m}};
      8'h14: r = {8{m}};
      8'h15: r = {8{b | v}};
      8'h16: r = {8{b | v}};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : prot_mask

  // Both colour and mono CRTC ports are decoded; no address-select bit is kept here
  assign crtcDataHit = (hostReq.addr == `CWGCS_PORT_CRTC_DAT_MONO) || (hostReq.addr == `CWGCS_PORT_CRTC_DAT_CLR);
  assign crtcWrite   = hostReq.wr && crtcDataHit && (crtcIndex < `CWGCS_CRTC_COUNT);
  assign wrMask      = prot_mask(crtcIndex, timingWriteGuard);

  // Index registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gfxIndex  <= 8'h00;
      crtcIndex <= 8'h00;
    end
    else if (hostReq.wr)
    begin
      if (hostReq.addr == `CWGCS_PORT_GFX_INDEX)
      begin
        gfxIndex <= hostReq.wrData;
      end
      if ((hostReq.addr == `CWGCS_PORT_CRTC_IDX_MONO) || (hostReq.addr == `CWGCS_PORT_CRTC_IDX_CLR))
      begin
        crtcIndex <= hostReq.wrData;
      end
    end
  end

  // Extension registers behind the graphics data port
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timingWriteGuard <= `CWGCS_GUARD_RESET;
      videoClockSelect <= `CWGCS_CLK_RESET;
    end
    else if (hostReq.wr && (hostReq.addr == `CWGCS_PORT_GFX_DATA))
    begin
      if (gfxIndex == `CWGCS_IDX_WRITE_GUARD)
      begin
        timingWriteGuard <= hostReq.wrData & `CWGCS_GUARD_MASK;
      end
      if (gfxIndex == `CWGCS_IDX_CLOCK_SELECT)
      begin
        videoClockSelect <= hostReq.wrData & `CWGCS_CLK_MASK;
      end
    end
  end

  // Only the clock bits of the general output register matter to this block
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      miscClk <= `CWGCS_MISC_RESET;
    end
    else if (hostReq.wr && (hostReq.addr == `CWGCS_PORT_MISC_WR))
    begin
      miscClk <= hostReq.wrData[`CWGCS_MISC_CLK_HI:`CWGCS_MISC_CLK_LO];
    end
  end

  // Protected bits keep their value in both copies; the CRTC sees the working set for protected bits, the standard set for the rest
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      crtcStd  <= '0;
      crtcWork <= '0;
    end
    else if (crtcWrite)
    begin
      crtcStd[crtcIndex[4:0]]  <= (crtcStd[crtcIndex[4:0]] & wrMask) | (hostReq.wrData & ~wrMask);
      crtcWork[crtcIndex[4:0]] <= (crtcWork[crtcIndex[4:0]] & wrMask) | (hostReq.wrData & ~wrMask);
    end
  end

  // Output is registered, so a write shows at the CRTC two edges after its strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      crtcTiming <= '0;
    end
    else
    begin
      for (int i = 0; i < `CWGCS_CRTC_COUNT; i++)
      begin
        crtcTiming[i] <= (crtcWork[i] & prot_mask(8'(i), timingWriteGuard))
                       | (crtcStd[i] & ~prot_mask(8'(i), timingWriteGuard));
      end
    end
  end

  // Attribute palette
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      paletteEntries <= '0;
    end
    else if (attrReq.wr && !timingWriteGuard[`CWGCS_GUARD_PAL] && (attrReq.index < `CWGCS_PAL_COUNT))
    begin
      paletteEntries[attrReq.index[3:0]] <= attrReq.data;
    end
  end

  // Video clock select code
  always_comb
  begin
    if (videoClockSelect[`CWGCS_CLK_SRC])
    begin
      next_code = videoClockSelect[`CWGCS_CLK_CODE_HI:`CWGCS_CLK_CODE_LO];
    end
    else
    begin
      next_code = {videoClockSelect[`CWGCS_CLK_CODE_HI:`CWGCS_CLK_CODE_MID], miscClk};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      videoClockSel <= '0;
    end
    else
    begin
      videoClockSel.code  <= next_code;
      videoClockSel.halve <= videoClockSelect[`CWGCS_CLK_HALVE];
    end
  end

  // Read path; unmapped ports and indexes read zero
  always_comb
  begin
    next_rdData = 8'h00;
    case (hostReq.addr)
      `CWGCS_PORT_GFX_INDEX: next_rdData = gfxIndex;
      `CWGCS_PORT_GFX_DATA:
      begin
        if (gfxIndex == `CWGCS_IDX_WRITE_GUARD)
        begin
          next_rdData = timingWriteGuard;
        end
        else if (gfxIndex == `CWGCS_IDX_CLOCK_SELECT)
        begin
          next_rdData = videoClockSelect;
        end
      end
      `CWGCS_PORT_CRTC_IDX_MONO: next_rdData = crtcIndex;
      `CWGCS_PORT_CRTC_IDX_CLR:  next_rdData = crtcIndex;
      `CWGCS_PORT_CRTC_DAT_MONO,
      `CWGCS_PORT_CRTC_DAT_CLR:
      begin
        if (crtcIndex < `CWGCS_CRTC_COUNT)
        begin
          next_rdData = crtcStd[crtcIndex[4:0]];
        end
      end
      `CWGCS_PORT_MISC_RD: next_rdData = {4'h0, miscClk, 2'h0};
      default: next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hostRdData  <= 8'h00;
      hostRdValid <= 1'b0;
    end
    else
    begin
      hostRdValid <= hostReq.rd;
      if (hostReq.rd)
      begin
        hostRdData <= next_rdData;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic gfxGuardRd;
  logic crtcWr00;
  assign gfxGuardRd = hostReq.rd && (hostReq.addr == `CWGCS_PORT_GFX_DATA) && (gfxIndex == `CWGCS_IDX_WRITE_GUARD);
  assign crtcWr00   = crtcWrite && (crtcIndex == 8'h00);

  property p_guard_read;
    gfxGuardRd |=> hostRdValid && (hostRdData == $past(timingWriteGuard));
  endproperty
  a_guard_read: assert property (p_guard_read) else $error("guard readback wrong");
  property p_pal_guard;
    attrReq.wr && timingWriteGuard[6] |=> $stable(paletteEntries);
  endproperty
  a_pal_guard: assert property (p_pal_guard) else $error("guarded palette changed");
  property p_total_guard;
    crtcWr00 && timingWriteGuard[4] |-> ##2 $stable(crtcTiming[0]);
  endproperty
  a_total_guard: assert property (p_total_guard) else $error("guarded total changed");
  property p_open_write;
    crtcWr00 && (timingWriteGuard == 8'h00) |-> ##2 crtcTiming[0] == $past(hostReq.wrData, 2);
  endproperty
  a_open_write: assert property (p_open_write) else $error("unguarded write lost");
  property p_blank_guard;
    crtcWrite && (crtcIndex == 8'h02) && timingWriteGuard[3] |-> ##2 $stable(crtcTiming[2]);
  endproperty
  a_blank_guard: assert property (p_blank_guard) else $error("guarded blank changed");
  property p_vde_guard;
    crtcWrite && (crtcIndex == 8'h12) && timingWriteGuard[2] |-> ##2 $stable(crtcTiming[18]);
  endproperty
  a_vde_guard: assert property (p_vde_guard) else $error("guarded display end changed");
  property p_timing_guard;
    crtcWrite && (crtcIndex == 8'h0A) && timingWriteGuard[1] |-> ##2 $stable(crtcTiming[10]);
  endproperty
  a_timing_guard: assert property (p_timing_guard) else $error("guarded cursor changed");
  property p_vert_guard;
    crtcWrite && (crtcIndex == 8'h06) && timingWriteGuard[0] |-> ##2 $stable(crtcTiming[6]);
  endproperty
  a_vert_guard: assert property (p_vert_guard) else $error("guarded vertical total changed");

  property p_own_code;
    videoClockSelect[7] |=> videoClockSel.code == $past(videoClockSelect[5:2]);
  endproperty
  a_own_code: assert property (p_own_code) else $error("own clock code wrong");

  property p_mixed_code;
    !videoClockSelect[7] |=> videoClockSel.code == {$past(videoClockSelect[5:4]), $past(miscClk)};
  endproperty
  a_mixed_code: assert property (p_mixed_code) else $error("mixed clock code wrong");

  property p_halve;
    ##1 videoClockSel.halve == $past(videoClockSelect[1]);
  endproperty
  a_halve: assert property (p_halve) else $error("halving flag wrong");

  property p_any_guard;
    crtcWrite && (crtcIndex == 8'h07) && (timingWriteGuard[2] || timingWriteGuard[1])
      |-> ##2 (crtcTiming[7] & 8'h42) == ($past(crtcTiming[7]) & 8'h42);
  endproperty
  a_any_guard: assert property (p_any_guard) else $error("shared overflow bits changed");

  property p_cv_guarded;
    crtcWr00 && timingWriteGuard[4];
  endproperty
  c_cv_guarded: cover property (p_cv_guarded);
  property p_cv_open;
    crtcWr00 && (timingWriteGuard == 8'h00);
  endproperty
  c_cv_open: cover property (p_cv_open);
  property p_cv_pal_block;
    attrReq.wr && timingWriteGuard[6];
  endproperty
  c_cv_pal_block: cover property (p_cv_pal_block);
  property p_cv_clk_own;
    videoClockSelect[7] && videoClockSelect[1];
  endproperty
  c_cv_clk_own: cover property (p_cv_clk_own);

endmodule : cwgcs_core
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the CRTC write guard and video clock select block.
// Assumes the core decodes host I/O strobes on ref_clk and asserts rules inside itself.
`timescale 1ns/1ps
`default_nettype none
`include "cwgcs_params.svh"

module tb_top;
  logic                       ref_clk;
  logic                       rst;
  cwgcs_pkg::cwgcs_host_req_s hostReq;
  cwgcs_pkg::cwgcs_attr_req_s attrReq;
  logic [7:0]                 hostRdData;
  logic                       hostRdValid;
  cwgcs_pkg::cwgcs_crtc_file_t crtcTiming;
  cwgcs_pkg::cwgcs_pal_file_t  paletteEntries;
  cwgcs_pkg::cwgcs_clk_sel_s   videoClockSel;
  int                         errTotal;
  int                         checksDone;
  int                         cycleCount;
  logic [7:0]                 rdVal;
  logic [7:0]                 gv [11];
  logic [7:0]                 ci [11];
  logic [7:0]                 ex [11];

  cwgcs_core i_cwgcs_core (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .hostReq        (hostReq),
    .attrReq        (attrReq),
    .hostRdData     (hostRdData),
    .hostRdValid    (hostRdValid),
    .crtcTiming     (crtcTiming),
    .paletteEntries (paletteEntries),
    .videoClockSel  (videoClockSel)
  );

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic wrapUp();
    if (errTotal == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrapUp

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000)
    begin
      errTotal = errTotal + 1;
      wrapUp();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checksDone = checksDone + 1;
    if (seen !== exp)
    begin
      errTotal = errTotal + 1;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic ioWr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hostReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    hostReq.wr <= 1'b0;
  endtask : ioWr

  // Read answer may land one edge after the taking edge; wait is bounded
  task automatic ioRd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    hostReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    hostReq.rd <= 1'b0;
    n = 0;
    #1;
    while (hostRdValid !== 1'b1 && n < 4)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (hostRdValid !== 1'b1)
      chk(8'hEE, 8'h00, "read answer missing");
    d = hostRdData;
  endtask : ioRd

  task automatic gfxWr(input logic [7:0] i, input logic [7:0] d);
    ioWr(`CWGCS_PORT_GFX_INDEX, i);
    ioWr(`CWGCS_PORT_GFX_DATA, d);
  endtask : gfxWr

  task automatic gfxRd(input logic [7:0] i, output logic [7:0] d);
    ioWr(`CWGCS_PORT_GFX_INDEX, i);
    ioRd(`CWGCS_PORT_GFX_DATA, d);
  endtask : gfxRd

  task automatic crtcWr(input logic [7:0] i, input logic [7:0] d);
    ioWr(`CWGCS_PORT_CRTC_IDX_CLR, i);
    ioWr(`CWGCS_PORT_CRTC_DAT_CLR, d);
  endtask : crtcWr

  task automatic attrWr(input logic [4:0] i, input logic [5:0] d);
    @(posedge ref_clk);
    attrReq <= '{index: i, data: d, wr: 1'b1};
    @(posedge ref_clk);
    attrReq.wr <= 1'b0;
  endtask : attrWr

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  initial
  begin
    // Guard value, CRTC index, expected effective value after 00 then FF
    gv = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h05, 8'h10, 8'h10, 8'h08, 8'h02, 8'h01};
    ci = '{8'h00, 8'h03, 8'h12, 8'h09, 8'h11, 8'h07, 8'h05, 8'h14, 8'h02, 8'h0A, 8'h06};
    ex = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'hF0, 8'h10, 8'hE0, 8'hFF, 8'h00, 8'h00, 8'h00};
    errTotal = 0;
    checksDone = 0;
    cycleCount = 0;
    rst = 1'b1;
    hostReq = '0;
    attrReq = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk({4'h0, videoClockSel.code}, 8'h08, "reset clock code");
    chk({7'h0, videoClockSel.halve}, 8'h00, "reset halve");
    gfxRd(`CWGCS_IDX_WRITE_GUARD, rdVal);
    chk(rdVal, 8'h00, "guard reset");
    gfxRd(`CWGCS_IDX_CLOCK_SELECT, rdVal);
    chk(rdVal, 8'h20, "clock select reset");
    gfxRd(8'h85, rdVal);
    chk(rdVal, 8'h00, "unmapped index");

    gfxWr(`CWGCS_IDX_CLOCK_SELECT, 8'hFF);
    gfxRd(`CWGCS_IDX_CLOCK_SELECT, rdVal);
    chk(rdVal, 8'hBE, "clock select mask");
    chk({4'h0, videoClockSel.code}, 8'h0F, "own code");
    chk({7'h0, videoClockSel.halve}, 8'h01, "halve on");
    ioWr(`CWGCS_PORT_MISC_WR, 8'h04);
    gfxWr(`CWGCS_IDX_CLOCK_SELECT, 8'h30);
    settle();
    chk({4'h0, videoClockSel.code}, 8'h0D, "mixed code");
    chk({7'h0, videoClockSel.halve}, 8'h00, "halve off");
    ioRd(`CWGCS_PORT_MISC_RD, rdVal);
    chk(rdVal, 8'h04, "misc readback");
    gfxWr(`CWGCS_IDX_CLOCK_SELECT, 8'hB0);
    settle();
    chk({4'h0, videoClockSel.code}, 8'h0C, "own code ignores misc");

    // Unguarded write through the mono alias reaches the effective set
    gfxWr(`CWGCS_IDX_WRITE_GUARD, 8'h00);
    ioWr(`CWGCS_PORT_CRTC_IDX_MONO, 8'h00);
    ioWr(`CWGCS_PORT_CRTC_DAT_MONO, 8'h5A);
    settle();
    chk(crtcTiming[0], 8'h5A, "unguarded write");
    // Index 20h aliases entry 0 in the low bits, so a missed refusal shows here
    crtcWr(8'h20, 8'h77);
    settle();
    chk(crtcTiming[0], 8'h5A, "out of range index refused");
    ioWr(`CWGCS_PORT_CRTC_IDX_MONO, 8'h00);
    ioRd(`CWGCS_PORT_CRTC_DAT_MONO, rdVal);
    chk(rdVal, 8'h5A, "standard copy readback");
    ioRd(`CWGCS_PORT_CRTC_IDX_CLR, rdVal);
    chk(rdVal, 8'h00, "crtc index readback");

    for (int k = 0; k < 11; k++)
    begin
      gfxWr(`CWGCS_IDX_WRITE_GUARD, 8'h00);
      crtcWr(ci[k], 8'h00);
      gfxWr(`CWGCS_IDX_WRITE_GUARD, gv[k] | 8'hA0);
      gfxRd(`CWGCS_IDX_WRITE_GUARD, rdVal);
      chk(rdVal, gv[k], "guard readback");
      crtcWr(ci[k], 8'hFF);
      settle();
      chk(crtcTiming[ci[k]], ex[k], "guarded write");
    end

    gfxWr(`CWGCS_IDX_WRITE_GUARD, 8'h00);
    attrWr(5'h03, 6'h2A);
    attrWr(5'h0F, 6'h15);
    settle();
    chk({2'b00, paletteEntries[3]}, 8'h2A, "palette write");
    chk({2'b00, paletteEntries[15]}, 8'h15, "palette last entry");
    gfxWr(`CWGCS_IDX_WRITE_GUARD, 8'h40);
    attrWr(5'h03, 6'h15);
    settle();
    chk({2'b00, paletteEntries[3]}, 8'h2A, "palette guarded");
    gfxWr(`CWGCS_IDX_WRITE_GUARD, 8'h00);
    attrWr(5'h03, 6'h33);
    settle();
    chk({2'b00, paletteEntries[3]}, 8'h33, "palette unguarded again");
    // Index 13h shares its low bits with entry 3
    attrWr(5'h13, 6'h0C);
    settle();
    chk({2'b00, paletteEntries[3]}, 8'h33, "palette index out of range");
    wrapUp();
  end
endmodule : tb_top
`default_nettype wire
